/* hdl/nand_host.sv */
// Host-side controller that drives a byte-wide NAND flash through its pins.
//
// Overview of operation
// - Host holds byte valid across the rising edge of the input strobe.
// - Host keeps spare disable low unless a spare-skipping read is wanted.
// - Latches low, select low, input strobe high; toggling output strobe streams bytes.
// - At most 2 main and 3 spare partial programs per page.
// - Expect 4,026 good blocks; never program or erase bad ones.
// - Command latch high makes the strobed byte a command.
// - Address latch high makes the strobed byte an address.
// - Four address cycles: column first, then row bytes low to high.
`timescale 1ns/1ps
module nand_host (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst,
    // Request port.
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [1:0] req_op,
    input  wire logic [7:0] req_data,
    input  wire logic       req_spare,
    input  wire logic       req_end,
    input  wire logic       req_bad_block,
    input  wire logic       skip_spare,
    // Answer port.
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            rsp_refused,
    output logic            flash_busy,
    // Flash pins.
    output logic            cmd_latch,
    output logic            addr_latch,
    output logic            chip_sel_n,
    output logic            input_strobe_n,
    output logic            output_strobe_n,
    output logic            lockout_n,
    output logic            spare_off,
    output logic [7:0]      io_out,
    output logic            io_oe_n,
    input  wire logic [7:0] io_in,
    input  wire logic       ready_busy_n
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_WLOW  = 5'h02,
        ST_WHIGH = 5'h04,
        ST_RLOW  = 5'h08,
        ST_BUSY  = 5'h10
    } state_t;

    state_t     state;
    state_t     next_state;
    logic [3:0] timer;
    logic [3:0] next_timer;
    logic [7:0] next_io_out;
    logic [7:0] next_rsp_data;
    logic       next_rsp_valid;
    logic       next_rsp_refused;
    logic       cmd_latch_q;
    logic       next_cle;
    logic       addr_latch_q;
    logic       next_ale;
    logic       sel;
    logic       next_sel;
    logic       arm;
    logic       next_arm;
    logic [1:0] main_cnt;
    logic [1:0] next_main_cnt;
    logic [1:0] spare_cnt;
    logic [1:0] next_spare_cnt;
    logic [2:0] addr_cnt;
    logic [2:0] next_addr_cnt;
    logic [8:0] pins_sync;
    logic [7:0] io_sync;
    logic       rb_sync;

    // Flash data pins and busy line cross into mclk through two flops.
    nand_pin_sync #(.WIDTH(9)) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .pin_in   ({ready_busy_n, io_in}),
        .pin_sync (pins_sync)
    );
    assign io_sync = pins_sync[7:0];
    assign rb_sync = pins_sync[8];   // Open-drain line is valid even deselected.

    // Decide whether a command may go out; status and reset are allowed while busy.
    function automatic logic cmd_ok(input logic [7:0] c, input logic busy);
        cmd_ok = !busy || c == nand_host_pkg::CMD_STATUS || c == nand_host_pkg::CMD_RESET;
    endfunction

    // Pin decode from state; latches come from flops so they never glitch around the strobe.
    always_comb begin
        req_ready       = (state == ST_IDLE);
        cmd_latch       = cmd_latch_q;
        addr_latch      = addr_latch_q;
        input_strobe_n  = (state != ST_WLOW);           // Rising edge leaves ST_WLOW.
        output_strobe_n = (state != ST_RLOW);           // One fall per read byte.
        io_oe_n         = !(state == ST_WLOW || state == ST_WHIGH); // Bus free while reading.
        lockout_n       = 1'b1;                         // Held high so program and erase finish.
        spare_off       = skip_spare;                   // Caller raises it only for spare-skipping reads.
        chip_sel_n      = !sel;
        flash_busy      = !rb_sync || state == ST_BUSY;
    end

    // Next-state logic for the pin sequencer and the page bookkeeping.
    always_comb begin
        next_state       = state;
        next_timer       = (timer != 4'h0) ? timer - 4'h1 : 4'h0;
        next_io_out      = io_out;
        next_rsp_data    = rsp_data;
        next_rsp_valid   = 1'b0;
        next_rsp_refused = 1'b0;
        next_cle         = cmd_latch_q;
        next_ale         = addr_latch_q;
        next_sel         = sel;
        next_arm         = arm;
        next_main_cnt    = main_cnt;
        next_spare_cnt   = spare_cnt;
        next_addr_cnt    = addr_cnt;
        case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    if ((req_op == nand_host_pkg::OP_CMD && !cmd_ok(req_data, !rb_sync))
                        || (req_op != nand_host_pkg::OP_CMD && !rb_sync)
                        || (req_op == nand_host_pkg::OP_CMD && req_bad_block
                            && (req_data == nand_host_pkg::CMD_PROG_GO
                                || req_data == nand_host_pkg::CMD_ERASE_GO))
                        || (req_op == nand_host_pkg::OP_CMD && req_data == nand_host_pkg::CMD_PROG_GO
                            && (req_spare ? spare_cnt == nand_host_pkg::SPARE_PROG_LIMIT
                                          : main_cnt == nand_host_pkg::MAIN_PROG_LIMIT))) begin
                        next_rsp_refused = 1'b1;
                    end else begin
                        next_sel    = 1'b1;
                        next_io_out = req_data;
                        next_cle    = (req_op == nand_host_pkg::OP_CMD);
                        next_ale    = (req_op == nand_host_pkg::OP_ADDR);
                        if (req_op == nand_host_pkg::OP_ADDR) begin
                            // Column byte first, then rows low to high.
                            next_addr_cnt = (addr_cnt == 3'(nand_host_pkg::ADDR_CYCLES - 1)) ? 3'h0
                                                                                             : addr_cnt + 3'h1;
                        end
                        if (req_op == nand_host_pkg::OP_CMD && req_data == nand_host_pkg::CMD_PROG_GO) begin
                            if (req_spare) next_spare_cnt = spare_cnt + 2'h1;
                            else next_main_cnt = main_cnt + 2'h1;
                        end
                        if (req_op == nand_host_pkg::OP_CMD && req_data == nand_host_pkg::CMD_ERASE_GO) begin
                            next_main_cnt  = 2'h0;
                            next_spare_cnt = 2'h0;
                        end
                        next_arm = (req_op == nand_host_pkg::OP_CMD)
                                   && (req_data == nand_host_pkg::CMD_PROG_GO
                                       || req_data == nand_host_pkg::CMD_ERASE_GO);
                        if (req_op == nand_host_pkg::OP_RDATA) begin
                            next_state = ST_RLOW;
                            next_timer = 4'(nand_host_pkg::READ_WAIT_CYC);
                        end else begin
                            next_state = ST_WLOW;
                            next_timer = 4'(nand_host_pkg::STROBE_LOW_CYC);
                        end
                    end
                end
            end
            ST_WLOW: begin
                if (timer == 4'h0) begin
                    next_state = ST_WHIGH;
                    next_timer = 4'(nand_host_pkg::STROBE_HIGH_CYC);
                end
            end
            ST_WHIGH: begin
                if (timer == 4'h0) begin
                    next_cle = 1'b0;
                    next_ale = 1'b0;
                    if (arm) begin
                        next_state = ST_BUSY;     // Device keeps select high ignored here.
                        next_timer = 4'(nand_host_pkg::BUSY_START_CYC);
                    end else begin
                        next_state = ST_IDLE;
                        next_rsp_valid = 1'b1;
                        next_sel   = !req_end;
                    end
                end
            end
            ST_RLOW: begin
                if (timer == 4'h0) begin
                    next_rsp_data  = io_sync;
                    next_rsp_valid = 1'b1;
                    next_state     = ST_IDLE;
                    next_sel       = !req_end;    // Dropping select ends the read.
                end
            end
            ST_BUSY: begin
                // Wait out the busy-start delay, then for busy to clear.
                if (timer == 4'h0 && rb_sync) begin
                    next_arm       = 1'b0;
                    next_sel       = 1'b0;
                    next_rsp_valid = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Register every piece of sequencer state.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state        <= ST_IDLE;
            timer        <= 4'h0;
            io_out       <= 8'h00;
            rsp_data     <= 8'h00;
            rsp_valid    <= 1'b0;
            rsp_refused  <= 1'b0;
            cmd_latch_q  <= 1'b0;
            addr_latch_q <= 1'b0;
            sel          <= 1'b0;
            arm          <= 1'b0;
            main_cnt     <= 2'h0;
            spare_cnt    <= 2'h0;
            addr_cnt     <= 3'h0;
        end else begin
            state        <= next_state;
            timer        <= next_timer;
            io_out       <= next_io_out;
            rsp_data     <= next_rsp_data;
            rsp_valid    <= next_rsp_valid;
            rsp_refused  <= next_rsp_refused;
            cmd_latch_q  <= next_cle;
            addr_latch_q <= next_ale;
            sel          <= next_sel;
            arm          <= next_arm;
            main_cnt     <= next_main_cnt;
            spare_cnt    <= next_spare_cnt;
            addr_cnt     <= next_addr_cnt;
        end
    end

    // Block zero needs no bad-block screening, but a program or erase confirm with req_bad_block flagged is refused for any block, block zero included.

    a_bus_off_read: assert property (@(posedge mclk) disable iff (rst)
        !output_strobe_n |-> io_oe_n) else $error("Bus driven during read strobe");
    a_strobe_width: assert property (@(posedge mclk) disable iff (rst)
        $fell(input_strobe_n) |-> !input_strobe_n [*2]) else $error("Input strobe too short");
    a_latch_excl: assert property (@(posedge mclk) disable iff (rst)
        !(cmd_latch && addr_latch)) else $error("Both latches high");
    a_read_sample: assert property (@(posedge mclk) disable iff (rst)
        $fell(output_strobe_n) |-> !output_strobe_n [*4]) else $error("Read sampled early");
    a_strobe_excl: assert property (@(posedge mclk) disable iff (rst)
        !(!output_strobe_n && !input_strobe_n)) else $error("Both strobes low");
    a_lock_high: assert property (@(posedge mclk) disable iff (rst)
        lockout_n) else $error("Lockout dropped");
    a_sel_in_op: assert property (@(posedge mclk) disable iff (rst)
        (!input_strobe_n || !output_strobe_n) |-> !chip_sel_n) else $error("Strobe while deselected");
    a_main_limit: assert property (@(posedge mclk) disable iff (rst)
        main_cnt <= nand_host_pkg::MAIN_PROG_LIMIT) else $error("Main partial limit exceeded");
    c_write: cover property (@(posedge mclk) $rose(input_strobe_n));
    c_read: cover property (@(posedge mclk) rsp_valid && !$past(output_strobe_n));
    c_refuse: cover property (@(posedge mclk) rsp_refused);
    c_busy: cover property (@(posedge mclk) state == ST_BUSY ##1 state == ST_IDLE);
endmodule

/* hdl/nand_host_pkg.sv */
// Shared constants for the NAND flash host controller.
package nand_host_pkg;
    // Clock rate and pin timing (ns), with cycle counts derived from them.
    localparam int CLK_PERIOD_NS   = 20;
    localparam int STROBE_LOW_NS   = 35;
    localparam int STROBE_HIGH_NS  = 25;
    localparam int READ_ACCESS_NS  = 35;
    localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Access time plus two synchroniser stages on the data pins.
    localparam int READ_WAIT_CYC   = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    localparam int TIMER_W         = 4;
    // Busy-line settle window: the device may take this long to pull busy low.
    localparam int BUSY_START_NS   = 100;
    localparam int BUSY_START_CYC  = (BUSY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    // Partial program limits per page before erase.
    localparam logic [1:0] MAIN_PROG_LIMIT  = 2'h2;
    localparam logic [1:0] SPARE_PROG_LIMIT = 2'h3;
    // Array geometry.
    localparam int BLOCK_W          = 12;
    localparam logic [11:0] GOOD_BLOCK_MIN  = 12'hfba; // 4,026 blocks.
    localparam int ADDR_CYCLES      = 4;
    // Host request kinds.
    localparam logic [1:0] OP_CMD   = 2'h0;
    localparam logic [1:0] OP_ADDR  = 2'h1;
    localparam logic [1:0] OP_WDATA = 2'h2;
    localparam logic [1:0] OP_RDATA = 2'h3;
    // Commands that start array work, plus status and reset.
    localparam logic [7:0] CMD_PROG_GO  = 8'h10;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    localparam logic [7:0] CMD_STATUS   = 8'h70;
    localparam logic [7:0] CMD_RESET    = 8'hff;
endpackage

/* hdl/nand_pin_sync.sv */
// Two-flop synchroniser for the inputs that arrive from the flash pins.
`timescale 1ns/1ps
module nand_pin_sync #(
    parameter int WIDTH = 9
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst,
    // Pin side and synchronised side.
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    // Next values: the first stage feeds only the second.
    always_comb begin
        next_stage1 = pin_in;
        next_sync   = stage1;
    end

    // Both stages reset high, the idle level of the busy line.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1   <= '1;
            pin_sync <= '1;
        end else begin
            stage1   <= next_stage1;
            pin_sync <= next_sync;
        end
    end
endmodule

/* testbench/flash_model.sv */
// Behavioural byte-wide flash device that answers the host controller's pins.
`timescale 1ns/1ps
module flash_model #(
    parameter int READ_NS = 300,
    parameter int PROG_NS = 600
) (
    // Control pins from the host.
    input  wire logic       cmd_latch,
    input  wire logic       addr_latch,
    input  wire logic       chip_sel_n,
    input  wire logic       input_strobe_n,
    input  wire logic       output_strobe_n,
    input  wire logic       lockout_n,
    input  wire logic       spare_off,
    // Shared bus and status.
    input  wire logic [7:0] io_out,
    input  wire logic       io_oe_n,
    output logic      [7:0] io_in,
    output logic            ready_busy_n
);
    logic [7:0] last_cmd = 8'h00;
    logic [9:0] column = 10'h000;
    logic [2:0] addr_cnt = 3'h0;
    logic       busy = 1'b0;
    logic       busy_read = 1'b0;
    logic [7:0] dout = 8'h00;
    logic       dev_on;
    time        busy_end = 0;

    // Busy runs for a fixed time; a read can be cut short by deselection.
    always begin
        #10;
        if (busy && $time >= busy_end) begin
            busy = 1'b0;
            busy_read = 1'b0;
        end
    end

    // Bytes are taken on the rising edge of the input strobe while selected.
    always @(posedge input_strobe_n) begin
        if (!chip_sel_n && cmd_latch) begin
            last_cmd = io_in;
            addr_cnt = 3'h0;
            if (lockout_n && (io_in == 8'h10 || io_in == 8'hd0)) begin
                busy = 1'b1;
                busy_end = $time + PROG_NS;
            end
        end else if (!chip_sel_n && addr_latch) begin
            if (addr_cnt == 3'h0) column = {1'b0, last_cmd[0], io_in};
            addr_cnt = addr_cnt + 3'h1;
            if (last_cmd <= 8'h01 && addr_cnt == 3'h4) begin
                busy = 1'b1;
                busy_read = 1'b1;
                busy_end = $time + READ_NS;
            end
        end
    end

    // Deselecting abandons a read but never a program or erase.
    always @(posedge chip_sel_n) if (busy_read) busy_end = $time;

    // Each output strobe fall presents the next column, skipping spare if disabled.
    always @(negedge output_strobe_n) begin
        if (!chip_sel_n && !busy) begin
            dout = column[7:0] ^ {column[9:8], 6'h00};
            column = (spare_off && column == 10'h1ff) ? 10'h000 : column + 10'h001;
        end
    end

    // A released bus has no pull, so it shows a wrong value rather than the last byte.
    assign #35 dev_on = !chip_sel_n && !output_strobe_n && !busy;
    assign io_in = !io_oe_n ? io_out : (dev_on ? dout : ~dout);
    assign ready_busy_n = busy ? 1'b0 : 1'b1;
endmodule

/* testbench/tb_nand_host.sv */
// Self-checking bench for the NAND host controller against a behavioural flash.
`timescale 1ns/1ps
module tb_nand_host;
    typedef struct {
        logic [1:0] op;
        logic [7:0] data;
        logic       endf;
        logic       wait_idle;
        logic       refused;
        logic [7:0] rdata;
    } row_t;
    logic       mclk, rst, req_valid, req_ready, req_spare, req_end, req_bad_block, skip_spare;
    logic       rsp_valid, rsp_refused, flash_busy, cmd_latch, addr_latch, chip_sel_n;
    logic       input_strobe_n, output_strobe_n, lockout_n, spare_off, io_oe_n, ready_busy_n;
    logic [1:0] req_op;
    logic [7:0] req_data, rsp_data, io_out, io_in, d;
    logic       r;
    int         errors = 0, num_checks = 0, cycles = 0, i, k;
    row_t       rows [11] = '{
        '{nand_host_pkg::OP_CMD,   8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{nand_host_pkg::OP_ADDR,  8'h03, 1'b0, 1'b0, 1'b0, 8'h00},
        '{nand_host_pkg::OP_ADDR,  8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{nand_host_pkg::OP_ADDR,  8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{nand_host_pkg::OP_ADDR,  8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{nand_host_pkg::OP_RDATA, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00},
        '{nand_host_pkg::OP_CMD,   8'h80, 1'b0, 1'b0, 1'b1, 8'h00},
        '{nand_host_pkg::OP_CMD,   nand_host_pkg::CMD_STATUS, 1'b0, 1'b0, 1'b0, 8'h00},
        '{nand_host_pkg::OP_RDATA, 8'h00, 1'b0, 1'b1, 1'b0, 8'h03},
        '{nand_host_pkg::OP_RDATA, 8'h00, 1'b0, 1'b0, 1'b0, 8'h04},
        '{nand_host_pkg::OP_RDATA, 8'h00, 1'b1, 1'b0, 1'b0, 8'h05}};

    nand_host u_nand_host (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_data(req_data), .req_spare(req_spare), .req_end(req_end),
        .req_bad_block(req_bad_block), .skip_spare(skip_spare), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_refused(rsp_refused), .flash_busy(flash_busy),
        .cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n),
        .input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n), .lockout_n(lockout_n),
        .spare_off(spare_off), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
        .ready_busy_n(ready_busy_n));
    flash_model u_flash_model (.cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_sel_n(chip_sel_n),
        .input_strobe_n(input_strobe_n), .output_strobe_n(output_strobe_n), .lockout_n(lockout_n),
        .spare_off(spare_off), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
        .ready_busy_n(ready_busy_n));

    // Free-running 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // A hang is cut short well past the expected run length.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        num_checks++;
        if (seen !== expv) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    // One request held until taken, then a bounded wait for its answer.
    task automatic send(input logic [1:0] op, input logic [7:0] data, input logic spare, input logic endf,
                        input logic bad, output logic ref_seen, output logic [7:0] rd);
        int n;
        req_op = op;
        req_data = data;
        req_spare = spare;
        req_end = endf;
        req_bad_block = bad;
        req_valid = 1'b1;
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) begin
            @(posedge mclk);
            #2;
        end
        @(posedge mclk);
        #2;
        req_valid = 1'b0;
        for (n = 0; n < 400 && rsp_valid !== 1'b1 && rsp_refused !== 1'b1; n++) begin
            @(posedge mclk);
            #2;
        end
        if (n == 400) check(8'h01, 8'h00);
        ref_seen = rsp_refused;
        rd = rsp_data;
        // One spare edge, so a refused request never sees valid dropped and raised in one step.
        @(posedge mclk);
        #2;
    endtask

    // The busy flag is waited on only where the device is known to be working.
    task automatic idle();
        int n;
        for (n = 0; n < 400 && flash_busy !== 1'b0; n++) begin
            @(posedge mclk);
            #2;
        end
        if (n == 400) check(8'h01, 8'h00);
    endtask

    // Page program of block zero, with the bad-block flag taken from the caller.
    task automatic prog(input logic spare, input logic bad, input logic expect_ref);
        send(nand_host_pkg::OP_CMD, 8'h80, spare, 1'b0, 1'b0, r, d);
        for (k = 0; k < nand_host_pkg::ADDR_CYCLES; k++) send(nand_host_pkg::OP_ADDR, 8'h00, spare, 1'b0, 1'b0, r, d);
        send(nand_host_pkg::OP_WDATA, 8'ha5, spare, 1'b0, 1'b0, r, d);
        send(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_PROG_GO, spare, 1'b0, bad, r, d);
        check(r, expect_ref);
        check(ready_busy_n, 8'h01);
    endtask

    task automatic results();
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Reset, the table of ordinary transfers, then the awkward cases.
    initial begin
        rst = 1'b1;
        {req_valid, req_spare, req_end, req_bad_block, skip_spare} = 5'h00;
        req_op = 2'h0;
        req_data = 8'h00;
        repeat (2) @(posedge mclk);
        #2;
        check({chip_sel_n, io_oe_n, input_strobe_n, output_strobe_n, cmd_latch}, 8'h1e);
        rst = 1'b0;
        check(lockout_n, 8'h01);
        foreach (rows[j]) begin
            if (rows[j].wait_idle) idle();
            send(rows[j].op, rows[j].data, 1'b0, rows[j].endf, 1'b0, r, d);
            check(r, rows[j].refused);
            if (rows[j].op == nand_host_pkg::OP_RDATA && !rows[j].refused) check(d, rows[j].rdata);
        end
        check(chip_sel_n, 8'h01);
        // Reads across the main-to-spare boundary, with and without spare skipping.
        for (i = 0; i < 2; i++) begin
            skip_spare = i[0];
            send(nand_host_pkg::OP_CMD, 8'h01, 1'b0, 1'b0, 1'b0, r, d);
            send(nand_host_pkg::OP_ADDR, 8'hfe, 1'b0, 1'b0, 1'b0, r, d);
            for (k = 0; k < 3; k++) send(nand_host_pkg::OP_ADDR, 8'h00, 1'b0, 1'b0, 1'b0, r, d);
            idle();
            send(nand_host_pkg::OP_RDATA, 8'h00, 1'b0, 1'b0, 1'b0, r, d);
            check(d, 8'hbe);
            send(nand_host_pkg::OP_RDATA, 8'h00, 1'b0, 1'b0, 1'b0, r, d);
            check(d, 8'hbf);
            send(nand_host_pkg::OP_RDATA, 8'h00, 1'b0, 1'b1, 1'b0, r, d);
            check(d, i[0] ? 8'h00 : 8'h80);
            check(spare_off, i[0]);
        end
        skip_spare = 1'b0;
        // Partial program limits, an erase that restores the count, then a bad block.
        for (i = 0; i < 3; i++) prog(1'b0, 1'b0, i == 2);
        for (i = 0; i < 4; i++) prog(1'b1, 1'b0, i == 3);
        send(nand_host_pkg::OP_CMD, 8'h60, 1'b0, 1'b0, 1'b0, r, d);
        for (k = 0; k < 3; k++) send(nand_host_pkg::OP_ADDR, 8'h00, 1'b0, 1'b0, 1'b0, r, d);
        send(nand_host_pkg::OP_CMD, nand_host_pkg::CMD_ERASE_GO, 1'b0, 1'b0, 1'b0, r, d);
        check(r, 8'h00);
        // With the counts cleared, only the bad-block flag can cause this refusal.
        prog(1'b0, 1'b1, 1'b1);
        prog(1'b0, 1'b0, 1'b0);
        results();
    end
endmodule
